// File: verilog/csc_pkg.sv
// package: constants and carrier types for the cam start control block
package csc_pkg;
  localparam int POS_W = 32;
  localparam int CODE_W = 16;
  localparam int HANDLE_W = 16;
  localparam int TABLE_W = 16;
  localparam int SRC_W = 8;

  // start modes
  localparam logic START_AT_ONCE = 1'h0;
  localparam logic START_ON_POSITION_PASS = 1'h1;

  // leader source codes
  localparam logic [SRC_W-1:0] SRC_SET = 8'h01;
  localparam logic [SRC_W-1:0] SRC_ACTUAL = 8'h02;
  localparam logic [SRC_W-1:0] SRC_LATEST_SET = 8'h65;
  localparam logic [SRC_W-1:0] SRC_LATEST_ACTUAL = 8'h66;
  localparam logic [SRC_W-1:0] SRC_RESET = 8'h01;

  // queueing select
  localparam logic QUEUE_ABORT = 1'h0;
  localparam logic QUEUE_BUFFERED = 1'h1;

  // option bit that picks the pass-check position source
  localparam int OPT_PASS_SRC_BIT = 21;

  // fault codes, values arbitrary
  localparam logic [CODE_W-1:0] FAULT_NONE = 16'h0000;
  localparam logic [CODE_W-1:0] FAULT_BAD_SOURCE = 16'h0001;
  localparam logic [CODE_W-1:0] FAULT_BAD_TABLE = 16'h0002;
  localparam logic [CODE_W-1:0] FAULT_BAD_LENGTH = 16'h0003;

  // first handle handed out, value arbitrary
  localparam logic [HANDLE_W-1:0] HANDLE_BASE = 16'h0001;
  localparam logic [POS_W-1:0] POS_ZERO = 32'h00000000;

  typedef struct packed {
    logic [POS_W-1:0] leaderOffset;
    logic [POS_W-1:0] followerOffset;
    logic [POS_W-1:0] leaderScale;
    logic [POS_W-1:0] followerScale;
    logic [POS_W-1:0] leaderFollowDistance;
    logic [POS_W-1:0] leaderStartThreshold;
    logic syncStartSelect;
    logic [SRC_W-1:0] leaderSourceSelect;
    logic [TABLE_W-1:0] profileTableNumber;
    logic queueingSelect;
    logic [31:0] options;
  } csc_params_t;

  typedef struct packed {
    logic busy;
    logic active;
    logic outputLocked;
    logic aborted;
    logic fault;
    logic [CODE_W-1:0] faultCode;
    logic cycleComplete;
  } csc_status_t;
endpackage

// File: verilog/csc_pass_detect.sv
// pass detector: reports the first sample off the threshold after arming, then each crossing
`timescale 1ns/10ps
`default_nettype none
module csc_pass_detect (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic arm,
  input wire logic [csc_pkg::POS_W-1:0] threshold,
  input wire logic [csc_pkg::POS_W-1:0] position,
  // result
  output logic passed
);
  logic [1:0] sideReg;
  logic [1:0] sideNext;
  logic armedReg;
  wire logic above = $signed(position) > $signed(threshold);
  wire logic below = $signed(position) < $signed(threshold);

  // equal keeps the last known side, so only a real move off counts
  always_comb begin
    sideNext = sideReg;
    if (above) sideNext = 2'h2;
    else if (below) sideNext = 2'h1;
  end

  // equality never passes; leaving the value does
  assign passed = armedReg && !arm && ((sideReg == 2'h1 && above) ||
    (sideReg == 2'h2 && below) || (sideReg == 2'h0 && (above || below)));

  always_ff @(posedge core_clk) begin
    if (rst || arm) begin
      sideReg <= 2'h0;
      armedReg <= !rst;
    end else begin
      sideReg <= sideNext;
    end
  end
endmodule
`default_nettype wire

// File: verilog/csc_start_control.sv
// cam start control: latches start data, chooses sync start, reports flags
`timescale 1ns/10ps
`default_nettype none
module csc_start_control #(
  parameter logic [csc_pkg::HANDLE_W-1:0] INSTANCE_NUMBER = 16'h0000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // request from calling program
  input wire logic execute,
  input wire logic updateStrobe,
  input wire csc_pkg::csc_params_t params,
  input wire logic forcedStop,
  // leader and profile inputs
  input wire logic [csc_pkg::POS_W-1:0] leaderCommandPos,
  input wire logic [csc_pkg::POS_W-1:0] leaderFeedbackPos,
  input wire logic [csc_pkg::POS_W-1:0] cycleLength,
  input wire logic [csc_pkg::POS_W-1:0] profileValue,
  input wire logic profileOneShot,
  input wire logic tableValid,
  // status
  output csc_pkg::csc_status_t status,
  output logic [csc_pkg::HANDLE_W-1:0] instanceHandle,
  output logic [csc_pkg::POS_W-1:0] perCyclePosition,
  output logic [csc_pkg::POS_W-1:0] referenceValue,
  output logic [csc_pkg::POS_W-1:0] followerOutputValue,
  output csc_pkg::csc_params_t liveParams
);
  typedef enum logic [2:0] {IDLE, WAIT_PASS, RUNNING, DONE, ABORTED, FAULTED} csc_state_t;
  csc_state_t stateReg;
  csc_state_t stateNext;
  csc_pkg::csc_params_t paramReg;
  csc_pkg::csc_params_t pendingReg;
  logic pendingValidReg;
  logic executeDlyReg;
  logic [csc_pkg::POS_W-1:0] leaderBaseReg;
  logic [csc_pkg::POS_W-1:0] perCycleReg;
  logic [csc_pkg::POS_W-1:0] refReg;
  logic [csc_pkg::POS_W-1:0] outReg;
  logic cycleDoneReg;
  logic [csc_pkg::CODE_W-1:0] faultCodeReg;
  logic abortedReg;
  logic [csc_pkg::HANDLE_W-1:0] handleReg;

  wire logic executeRise = execute && !executeDlyReg;
  wire logic running = stateReg == WAIT_PASS || stateReg == RUNNING;
  // source chosen by the option bit of the captured options
  wire logic useFeedback = paramReg.options[csc_pkg::OPT_PASS_SRC_BIT];
  wire logic [csc_pkg::POS_W-1:0] passPos = useFeedback ? leaderFeedbackPos : leaderCommandPos;
  wire logic [csc_pkg::POS_W-1:0] leaderPos =
    (paramReg.leaderSourceSelect == csc_pkg::SRC_ACTUAL ||
     paramReg.leaderSourceSelect == csc_pkg::SRC_LATEST_ACTUAL) ? leaderFeedbackPos
                                                                 : leaderCommandPos;
  // legal source codes only
  wire logic srcOk = params.leaderSourceSelect == csc_pkg::SRC_SET ||
    params.leaderSourceSelect == csc_pkg::SRC_ACTUAL ||
    params.leaderSourceSelect == csc_pkg::SRC_LATEST_SET ||
    params.leaderSourceSelect == csc_pkg::SRC_LATEST_ACTUAL;
  wire logic lenOk = cycleLength != csc_pkg::POS_ZERO;
  wire logic [csc_pkg::CODE_W-1:0] startFault =
    !srcOk ? csc_pkg::FAULT_BAD_SOURCE :
    !tableValid ? csc_pkg::FAULT_BAD_TABLE :
    !lenOk ? csc_pkg::FAULT_BAD_LENGTH : csc_pkg::FAULT_NONE;
  // a new start while running aborts it unless queueing was chosen
  wire logic takeNew = executeRise && (!running || params.queueingSelect == csc_pkg::QUEUE_ABORT);
  wire logic queueNew = executeRise && running && params.queueingSelect == csc_pkg::QUEUE_BUFFERED;
  wire logic armPass;
  wire logic passed;
  // threshold only; follow distance ignored in position-pass mode
  csc_pass_detect passDetect (
    .core_clk(core_clk),
    .rst(rst),
    .arm(armPass),
    .threshold(paramReg.leaderStartThreshold),
    .position(passPos),
    .passed(passed)
  );

  wire logic [csc_pkg::POS_W-1:0] relPos = leaderPos - leaderBaseReg + paramReg.leaderOffset;
  // base steps forward one cycle length per wrap, so each full move is seen once
  wire logic wrapNow = stateReg == RUNNING && $signed(relPos) >= $signed(cycleLength);
  wire logic [csc_pkg::POS_W-1:0] baseWrapped = leaderBaseReg + cycleLength;
  wire logic [csc_pkg::POS_W-1:0] perCycleNext = wrapNow ? relPos - cycleLength : relPos;
  wire logic startNow = stateReg == WAIT_PASS && passed;
  wire logic endOneShot = wrapNow && profileOneShot;
  wire logic launchQueued = endOneShot && pendingValidReg;
  assign armPass = (takeNew && startFault == csc_pkg::FAULT_NONE &&
    params.syncStartSelect == csc_pkg::START_ON_POSITION_PASS);
  // parameter updates take effect at once in mode zero, at table start otherwise
  wire logic applyUpdate = updateStrobe && running &&
    (paramReg.syncStartSelect == csc_pkg::START_AT_ONCE || wrapNow);

  always_comb begin
    stateNext = stateReg;
    if (forcedStop && running) stateNext = ABORTED;
    else if (takeNew && startFault != csc_pkg::FAULT_NONE) stateNext = FAULTED;
    else if (takeNew) begin
      // mode zero enters RUNNING on the first clock edge that sees execute high, with no pass wait
      stateNext = params.syncStartSelect == csc_pkg::START_AT_ONCE ? RUNNING : WAIT_PASS;
    end else if (launchQueued) stateNext = RUNNING;
    else if (startNow) stateNext = RUNNING;
    else if (endOneShot) stateNext = DONE;
    else if ((stateReg == DONE || stateReg == FAULTED) && !execute) stateNext = IDLE;
    else if (stateReg == ABORTED && !execute) stateNext = IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stateReg <= IDLE;
      executeDlyReg <= 1'h0;
    end else begin
      stateReg <= stateNext;
      executeDlyReg <= execute;
    end
  end

  // capture everything first, then the operation runs on the copy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      paramReg <= '0;
      pendingReg <= '0;
      pendingValidReg <= 1'h0;
    end else begin
      if (takeNew) paramReg <= params;
      else if (launchQueued) paramReg <= pendingReg;
      else if (applyUpdate) paramReg <= params;
      if (queueNew) begin
        pendingReg <= params;
        pendingValidReg <= 1'h1;
      end else if (launchQueued || takeNew || stateNext == ABORTED) begin
        pendingValidReg <= 1'h0;
      end
    end
  end

  // tracked values reset to zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      perCycleReg <= csc_pkg::POS_ZERO;
      refReg <= csc_pkg::POS_ZERO;
      outReg <= csc_pkg::POS_ZERO;
      leaderBaseReg <= csc_pkg::POS_ZERO;
      cycleDoneReg <= 1'h0;
    end else begin
      cycleDoneReg <= wrapNow; // one cycle per full cycle length
      if ((takeNew && stateNext == RUNNING) || startNow || launchQueued) begin
        leaderBaseReg <= leaderPos;
        perCycleReg <= csc_pkg::POS_ZERO;
      end else if (stateReg == RUNNING) begin
        if (wrapNow) leaderBaseReg <= baseWrapped;
        perCycleReg <= perCycleNext;
        refReg <= profileValue;
        outReg <= profileValue + paramReg.followerOffset;
      end
    end
  end

  // aborted holds until execute falls fault code zero when clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      abortedReg <= 1'h0;
      faultCodeReg <= csc_pkg::FAULT_NONE;
    end else begin
      if (stateNext == ABORTED || (running && takeNew)) abortedReg <= 1'h1;
      else if (!execute) abortedReg <= 1'h0;
      if (takeNew) faultCodeReg <= startFault;
      else if (stateNext == IDLE) faultCodeReg <= csc_pkg::FAULT_NONE;
    end
  end

  // handle fixed when the instance comes up
  always_ff @(posedge core_clk) begin
    if (rst) handleReg <= csc_pkg::HANDLE_BASE;
    else handleReg <= csc_pkg::HANDLE_BASE + INSTANCE_NUMBER;
  end

  // busy drops on done, abort or fault
  assign status.busy = running;
  assign status.active = stateReg == RUNNING;
  assign status.outputLocked = stateReg == RUNNING;
  assign status.aborted = abortedReg;
  assign status.fault = faultCodeReg != csc_pkg::FAULT_NONE;
  assign status.faultCode = faultCodeReg;
  assign status.cycleComplete = cycleDoneReg;
  assign instanceHandle = handleReg;
  assign perCyclePosition = perCycleReg;
  assign referenceValue = refReg;
  assign followerOutputValue = outReg;
  assign liveParams = paramReg;
endmodule
`default_nettype wire

// File: tb/csc_chk.sv
// checker: port timing relations of the cam start control block
`timescale 1ns/10ps
`default_nettype none
module csc_chk #(
  parameter logic [csc_pkg::HANDLE_W-1:0] INSTANCE_NUMBER = 16'h0000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire logic execute,
  input wire logic forcedStop,
  input wire csc_pkg::csc_params_t params,
  input wire csc_pkg::csc_status_t status,
  input wire logic [csc_pkg::HANDLE_W-1:0] instanceHandle,
  input wire logic [csc_pkg::POS_W-1:0] perCyclePosition,
  input wire logic [csc_pkg::POS_W-1:0] followerOutputValue
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // fresh request while idle; a level held through reset is not a start
  sequence s_take;
    $rose(execute) && !status.busy && !$past(rst);
  endsequence
  a_busy_start: assert property (s_take |=> status.busy || status.fault)
    else $error("busy missing after start");
  a_sync_now: assert property (s_take ##0 !params.syncStartSelect |=> status.active || status.fault)
    else $error("immediate start not active");
  a_sync_wait: assert property (s_take ##0 params.syncStartSelect |=> !status.active)
    else $error("position start active too early");
  a_lock_active: assert property (status.outputLocked == status.active)
    else $error("locked and active differ");
  a_stop_abort: assert property (status.busy && forcedStop |=> !status.busy && status.aborted)
    else $error("stop did not abort");
  a_abort_clear: assert property (status.aborted && !execute |=> !status.aborted)
    else $error("aborted not cleared");
  a_fault_idle: assert property (status.fault |-> !status.busy && !status.active)
    else $error("fault while busy");
  a_pulse_once: assert property (status.cycleComplete |-> $past(status.active) ##1 !status.cycleComplete)
    else $error("cycle pulse wrong");
  a_reset_zero: assert property ($past(rst) |-> perCyclePosition == csc_pkg::POS_ZERO
    && followerOutputValue == csc_pkg::POS_ZERO && !status.outputLocked)
    else $error("values not zero after reset");
  a_handle_set: assert property (!$past(rst) |-> instanceHandle == csc_pkg::HANDLE_BASE + INSTANCE_NUMBER)
    else $error("handle wrong");
endmodule
bind csc_start_control csc_chk #(.INSTANCE_NUMBER(INSTANCE_NUMBER)) i_chk (.core_clk, .rst,
  .execute, .forcedStop, .params, .status, .instanceHandle, .perCyclePosition,
  .followerOutputValue);
`default_nettype wire

// File: tb/csc_caller.sv
// calling program model: execute level, start data and forced stop
`timescale 1ns/10ps
`default_nettype none
module csc_caller (
  // clock
  input wire logic core_clk,
  // requests toward the block
  output logic execute,
  output logic forcedStop,
  output csc_pkg::csc_params_t params
);
  initial begin
    execute = 1'b0;
    forcedStop = 1'b0;
    params = '0;
  end
  // data changes with the rise so it is captured on that edge
  task automatic start(input logic mode, input logic [7:0] src, input logic [31:0] thr);
    @(posedge core_clk);
    params <= '{leaderScale: 32'h00000001, followerScale: 32'h00000001, leaderStartThreshold: thr,
      syncStartSelect: mode, leaderSourceSelect: src, profileTableNumber: 16'h0001,
      queueingSelect: csc_pkg::QUEUE_ABORT, default: '0};
    execute <= 1'b1;
  endtask
  task automatic stop();
    @(posedge core_clk);
    forcedStop <= 1'b1;
    @(posedge core_clk);
    forcedStop <= 1'b0;
  endtask
  task automatic drop();
    @(posedge core_clk);
    execute <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_csc_start_control.sv
// testbench: scenario tasks for the cam start control block
`timescale 1ns/10ps
`default_nettype none
module tb_csc_start_control;
  logic core_clk;
  logic rst;
  logic tableValid;
  logic execute;
  logic forcedStop;
  logic [31:0] leaderPos;
  logic [31:0] refValue;
  logic [31:0] outValue;
  logic [31:0] perCycle;
  logic [15:0] handle;
  csc_pkg::csc_params_t params;
  csc_pkg::csc_params_t liveParams;
  csc_pkg::csc_status_t status;
  int badCount;
  int nTests;

  csc_caller i_caller (.core_clk, .execute, .forcedStop, .params);
  // instance number 3 so the handle differs from its base
  csc_start_control #(.INSTANCE_NUMBER(16'h0003)) i_dut (.core_clk, .rst, .execute,
    .updateStrobe(1'b0), .params, .forcedStop, .leaderCommandPos(leaderPos),
    .leaderFeedbackPos(leaderPos), .cycleLength(32'h00000010), .profileValue(32'h00000100),
    .profileOneShot(1'b0), .tableValid, .status, .instanceHandle(handle),
    .perCyclePosition(perCycle), .referenceValue(refValue), .followerOutputValue(outValue),
    .liveParams);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic lead(input logic [31:0] v);
    @(posedge core_clk);
    leaderPos <= v;
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tReset();
    cyc(1);
    check({status, refValue}, 64'h0);
    check({perCycle, outValue}, 64'h0);
    check(handle, csc_pkg::HANDLE_BASE + 16'h0003);
    $display("reset test done");
  endtask
  task automatic tMode0();
    int pulses;
    pulses = 0;
    i_caller.start(csc_pkg::START_AT_ONCE, csc_pkg::SRC_SET, 32'h00000000);
    cyc(2);
    check({status.busy, status.active, status.outputLocked}, 3'h7);
    check({liveParams.leaderSourceSelect, liveParams.profileTableNumber}, 24'h010001);
    // leader moves 44 from start, so two full cycles of 16
    for (int i = 1; i <= 11; i++) begin
      lead(32'(i * 4));
      #1;
      pulses += int'(status.cycleComplete);
    end
    cyc(2);
    check(pulses, 2);
    i_caller.stop();
    cyc(1);
    check({status.busy, status.aborted}, 2'h1);
    i_caller.drop();
    cyc(2);
    check(status.aborted, 1'h0);
    $display("immediate start test done");
  endtask
  task automatic tMode1();
    int n;
    lead(32'h00000064);
    i_caller.start(csc_pkg::START_ON_POSITION_PASS, csc_pkg::SRC_ACTUAL, 32'h00000064);
    cyc(4);
    check({status.busy, status.active}, 2'h2);
    lead(32'h0000006E);
    for (n = 0; n < 6 && status.active !== 1'b1; n++) begin
      cyc(1);
    end
    if (n == 6) begin
      badCount++;
      printVerdict();
    end
    check(status.outputLocked, 1'h1);
    i_caller.stop();
    i_caller.drop();
    cyc(2);
    $display("position pass test done");
  endtask
  task automatic tFaults();
    logic [7:0] src [6] = '{8'h01, 8'h02, 8'h65, 8'h66, 8'h07, 8'h01};
    logic [15:0] code [6] = '{csc_pkg::FAULT_NONE, csc_pkg::FAULT_NONE, csc_pkg::FAULT_NONE,
      csc_pkg::FAULT_NONE, csc_pkg::FAULT_BAD_SOURCE, csc_pkg::FAULT_BAD_TABLE};
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk);
      tableValid <= (k != 5);
      i_caller.start(csc_pkg::START_AT_ONCE, src[k], 32'h00000000);
      cyc(2);
      check({status.busy, status.fault, status.faultCode},
        {code[k] == csc_pkg::FAULT_NONE, code[k] != csc_pkg::FAULT_NONE, code[k]});
      i_caller.stop();
      i_caller.drop();
      cyc(2);
      check(status.faultCode, csc_pkg::FAULT_NONE);
    end
    $display("source and fault test done");
  endtask

  initial begin
    rst = 1'b1;
    tableValid = 1'b1;
    leaderPos = 32'h00000000;
    badCount = 0;
    nTests = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    tReset();
    tMode0();
    tMode1();
    tFaults();
    printVerdict();
  end
endmodule
`default_nettype wire
